// File: src/smi_buf2.sv
// Small valid/ready buffer for returned read words
`timescale 1ns/10ps
module smi_buf2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Offered word
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = PW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } smi_buf_regs_t;

  smi_buf_regs_t r_r;
  smi_buf_regs_t r_nxt;
  logic do_push;
  logic do_pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (r_r.count != CW'(DEPTH));
  assign out_valid = (r_r.count != '0);
  assign out_data = r_r.mem[r_r.rptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  // Pointer wrap kept explicit so a non power of two depth still works
  always_comb
  begin
    r_nxt = r_r;
    if (do_push)
    begin
      r_nxt.mem[r_r.wptr] = in_data;
      r_nxt.wptr = (r_r.wptr == PW'(DEPTH - 1)) ? '0 : r_r.wptr + PW'(1);
    end
    if (do_pop)
      r_nxt.rptr = (r_r.rptr == PW'(DEPTH - 1)) ? '0 : r_r.rptr + PW'(1);
    if (do_push && !do_pop)
      r_nxt.count = r_r.count + CW'(1);
    else if (do_pop && !do_push)
      r_nxt.count = r_r.count - CW'(1);
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end
endmodule : smi_buf2

// File: src/smi_ctrl.sv
// Programmable synchronous memory port controller (burst SRAM, ZBT SRAM, FIFO)
`timescale 1ns/10ps
module smi_ctrl
  import smi_pkg::*;
#(
  parameter bit IS_FIRST_PORT = 1'b1 // First instance when set
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic link_clk_first_in, // First interface clock source
  input wire logic link_clk_second_in, // Second interface clock source
  input wire logic [smi_pkg::SMI_NSP-1:0][1:0] read_latency_field, // Per space read latency
  input wire logic [smi_pkg::SMI_NSP-1:0][1:0] write_latency_field, // Per space write latency
  input wire logic [smi_pkg::SMI_NSP-1:0] chip_select_extension, // Per space CS extension
  input wire logic [smi_pkg::SMI_NSP-1:0] strobe_function_select, // Per space strobe role
  input wire logic [smi_pkg::SMI_NSP-1:0] interface_clock_select, // Per space clock choice
  input wire logic req_valid, // Access request
  output logic req_ready, // Request taken
  input wire logic req_write, // Write when high
  input wire logic [smi_pkg::SMI_SPW-1:0] req_space, // Chip select space
  input wire logic [smi_pkg::SMI_AW-1:0] req_addr, // Word address
  input wire logic [smi_pkg::SMI_DW-1:0] req_wdata, // Write word
  output logic rd_valid, // Read word available
  input wire logic rd_ready, // Consumer takes read word
  output logic [smi_pkg::SMI_DW-1:0] rd_data, // Read word
  output logic ext_clock_out_first, // Forwarded first interface clock
  output logic ext_clock_out_second, // Forwarded second interface clock
  output logic [smi_pkg::SMI_NSP-1:0] space_chip_select_n, // Chip selects, active low
  output logic shared_read_strobe_pin_n, // Address strobe or read enable
  output logic shared_output_strobe_pin_n, // Sync output enable
  output logic shared_write_strobe_pin_n, // Sync write enable
  output logic [smi_pkg::SMI_AW-1:0] mem_addr, // Memory address
  output logic [smi_pkg::SMI_DW-1:0] mem_data_out, // Data pin output value
  output logic mem_data_oe, // Data pin output enable
  input wire logic [smi_pkg::SMI_DW-1:0] mem_data_in, // Data pin input value
  output logic dram_clock_enable_out // Dram clock enable, first port only
);
  import smi_pkg::*;

  typedef struct packed {
    smi_state_t st;
    logic c1_s0;
    logic c1_s1;
    logic c1_prev;
    logic c2_s0;
    logic c2_s1;
    logic c2_prev;
    logic [SMI_DW-1:0] ed_s0;
    logic [SMI_DW-1:0] ed_s1;
    logic write;
    logic [SMI_SPW-1:0] space;
    logic [SMI_AW-1:0] addr;
    logic [SMI_DW-1:0] wdata;
    logic [SMI_LATW-1:0] lat;
    logic [SMI_LATW-1:0] cnt;
    logic [SMI_TCW-1:0] tcnt;
    logic cext;
    logic ren;
    logic csel;
    logic [SMI_NSP-1:0] cs;
    logic strobe;
    logic oe;
    logic we;
    logic data_oe;
    logic [SMI_DW-1:0] rdata;
    logic push;
    logic clk1_out;
    logic clk2_out;
    logic cke;
  } smi_ctrl_regs_t;

  smi_ctrl_regs_t r_r;
  smi_ctrl_regs_t r_nxt;
  logic tick1;
  logic tick2;
  logic tick;
  logic buf_in_ready;
  logic [SMI_NSP-1:0] space_onehot;

  // Rising edges of the synchronised interface clocks
  assign tick1 = r_r.c1_s1 && !r_r.c1_prev;
  assign tick2 = r_r.c2_s1 && !r_r.c2_prev;
  assign tick = (r_r.csel == SMI_CLK_SECOND) ? tick2 : tick1;
  // A read is taken while the buffer count shows room, not counting a FIFO-mode word pushed in that same cycle
  assign req_ready = (r_r.st == SMI_ST_IDLE) && (req_write || buf_in_ready);
  assign space_onehot = SMI_NSP'(1) << r_r.space;

  // Pins: strobes kept active high inside, inverted at the boundary
  // shared pin roles
  assign shared_read_strobe_pin_n = !r_r.strobe;
  assign shared_output_strobe_pin_n = !r_r.oe;
  assign shared_write_strobe_pin_n = !r_r.we;
  assign space_chip_select_n = ~r_r.cs;
  assign mem_addr = r_r.addr;
  assign mem_data_out = r_r.wdata;
  assign mem_data_oe = r_r.data_oe;
  assign ext_clock_out_first = r_r.clk1_out;
  assign ext_clock_out_second = r_r.clk2_out;
  assign dram_clock_enable_out = IS_FIRST_PORT ? r_r.cke : 1'b0;

  // Next state: synchronisers, clock forwarding and the access sequencer
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.push = 1'b0;
    r_nxt.c1_s0 = link_clk_first_in;
    r_nxt.c1_s1 = r_r.c1_s0;
    r_nxt.c1_prev = r_r.c1_s1;
    r_nxt.c2_s0 = link_clk_second_in;
    r_nxt.c2_s1 = r_r.c2_s0;
    r_nxt.c2_prev = r_r.c2_s1;
    r_nxt.ed_s0 = mem_data_in;
    r_nxt.ed_s1 = r_r.ed_s0;
    r_nxt.clk1_out = r_r.c1_s1;
    r_nxt.clk2_out = r_r.c2_s1;
    // enable rises on the first interface edge after reset
    if (IS_FIRST_PORT && tick1)
      r_nxt.cke = 1'b1;
    unique case (r_r.st)
      SMI_ST_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          r_nxt.write = req_write;
          r_nxt.space = req_space;
          r_nxt.addr = req_addr;
          r_nxt.wdata = req_wdata;
          r_nxt.csel = interface_clock_select[req_space];
          r_nxt.cext = chip_select_extension[req_space];
          r_nxt.ren = strobe_function_select[req_space];
          r_nxt.lat = req_write ? write_latency_field[req_space]
                                : read_latency_field[req_space];
          r_nxt.st = SMI_ST_CMD;
        end
      end
      SMI_ST_CMD:
      begin
        // Command goes out on the selected clock edge only
        if (tick)
        begin
          r_nxt.cs = space_onehot;
          r_nxt.tcnt = SMI_TC_ZERO;
          // read enable is not raised for writes
          r_nxt.strobe = !(r_r.write && r_r.ren);
          r_nxt.oe = !r_r.write;
          r_nxt.we = r_r.write;
          if (!r_r.write)
          begin
            r_nxt.cnt = r_r.lat;
            r_nxt.st = SMI_ST_RLAT;
          end
          // zero latency drives data with the command
          else if (r_r.lat == SMI_LAT_ZERO)
          begin
            r_nxt.data_oe = 1'b1;
            r_nxt.st = SMI_ST_WDATA;
          end
          else
          begin
            r_nxt.cnt = r_r.lat - SMI_LAT_ONE;
            r_nxt.st = SMI_ST_WLAT;
          end
        end
      end
      SMI_ST_RLAT:
      begin
        if (tick)
        begin
          r_nxt.tcnt = r_r.tcnt + SMI_TC_ONE;
          // select drops after the command cycle
          if (!r_r.cext)
            r_nxt.cs = '0;
          // address strobe is a single cycle pulse
          if (!r_r.ren)
            r_nxt.strobe = 1'b0;
          if (r_r.cnt == SMI_LAT_ZERO)
          begin
            r_nxt.rdata = r_r.ed_s1;
            r_nxt.push = 1'b1;
            r_nxt.oe = 1'b0;
            // extended select ends with output enable
            r_nxt.cs = '0;
            // deselect cycle; none in FIFO mode
            r_nxt.strobe = !r_r.ren;
            r_nxt.st = r_r.ren ? SMI_ST_IDLE : SMI_ST_DESEL;
          end
          else
            r_nxt.cnt = r_r.cnt - SMI_LAT_ONE;
        end
      end
      SMI_ST_WLAT:
      begin
        if (tick)
        begin
          r_nxt.tcnt = r_r.tcnt + SMI_TC_ONE;
          r_nxt.cs = '0;
          r_nxt.strobe = 1'b0;
          r_nxt.we = 1'b0;
          // data phase after the write latency
          if (r_r.cnt == SMI_LAT_ZERO)
          begin
            r_nxt.data_oe = 1'b1;
            r_nxt.st = SMI_ST_WDATA;
          end
          else
            r_nxt.cnt = r_r.cnt - SMI_LAT_ONE;
        end
      end
      SMI_ST_WDATA:
      begin
        if (tick)
        begin
          r_nxt.tcnt = r_r.tcnt + SMI_TC_ONE;
          r_nxt.cs = '0;
          r_nxt.we = 1'b0;
          r_nxt.data_oe = 1'b0;
          // deselect cycle; none in FIFO mode
          r_nxt.strobe = !r_r.ren;
          r_nxt.st = r_r.ren ? SMI_ST_IDLE : SMI_ST_DESEL;
        end
      end
      SMI_ST_DESEL:
      begin
        // Strobe with no select is the deselect the SRAM expects
        if (tick)
        begin
          r_nxt.strobe = 1'b0;
          r_nxt.st = SMI_ST_IDLE;
        end
      end
      default:
      begin
        r_nxt.st = SMI_ST_IDLE;
      end
    endcase
  end

  // State register; all fields reset to zero, strobes idle inactive
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  // Read words queue here, up to two, while the consumer stalls
  smi_buf2 #(
    .WIDTH(SMI_DW),
    .DEPTH(SMI_BUF_DEPTH)
  ) u_rd_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(r_r.push),
    .in_ready(buf_in_ready),
    .in_data(r_r.rdata),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // Checks on the sequencer
  property p_read_latency;
    @(posedge clk) disable iff (!nrst)
    r_r.push |-> (r_r.tcnt == ({1'b0, r_r.lat} + SMI_TC_ONE)) && !r_r.write;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read data sampled at wrong latency");

  property p_write_latency;
    @(posedge clk) disable iff (!nrst)
    $rose(r_r.data_oe) |-> (r_r.tcnt == {1'b0, r_r.lat}) && r_r.write;
  endproperty
  a_write_latency: assert property (p_write_latency)
    else $error("write data driven at wrong latency");

  property p_cs_short;
    @(posedge clk) disable iff (!nrst)
    ((r_r.cs != '0) && (!r_r.cext || r_r.write)) |-> (r_r.tcnt == SMI_TC_ZERO);
  endproperty
  a_cs_short: assert property (p_cs_short)
    else $error("chip select held past command cycle");

  property p_cs_follows_oe;
    @(posedge clk) disable iff (!nrst)
    (r_r.cext && !r_r.write) |-> ((r_r.cs != '0) == r_r.oe);
  endproperty
  a_cs_follows_oe: assert property (p_cs_follows_oe)
    else $error("extended chip select differs from output enable");

  property p_deselect;
    @(posedge clk) disable iff (!nrst)
    (r_r.st == SMI_ST_DESEL) && !$past(r_r.st == SMI_ST_DESEL)
      |-> r_r.strobe && (r_r.cs == '0) && !r_r.ren;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect cycle malformed");

  property p_fifo_read_enable;
    @(posedge clk) disable iff (!nrst)
    (r_r.ren && !r_r.write && (r_r.st != SMI_ST_IDLE))
      |-> (r_r.strobe == r_r.oe) && (r_r.st != SMI_ST_DESEL);
  endproperty
  a_fifo_read_enable: assert property (p_fifo_read_enable)
    else $error("read enable mismatch in fifo mode");

  property p_clock_paced;
    @(posedge clk) disable iff (!nrst)
    ($changed(r_r.cs) || $changed(r_r.we) || $changed(r_r.data_oe)) |-> $past(tick);
  endproperty
  a_clock_paced: assert property (p_clock_paced)
    else $error("pin changed off the selected clock edge");

  property p_pin_roles;
    @(posedge clk) disable iff (!nrst)
    (r_r.we |-> r_r.write && !r_r.oe) and (r_r.oe |-> !r_r.write);
  endproperty
  a_pin_roles: assert property (p_pin_roles)
    else $error("output and write enable roles crossed");

  property p_cke_port;
    @(posedge clk) disable iff (!nrst)
    (!IS_FIRST_PORT |-> !dram_clock_enable_out)
      and ($rose(dram_clock_enable_out) |-> $past(tick1));
  endproperty
  a_cke_port: assert property (p_cke_port)
    else $error("dram clock enable misbehaves");

  property p_no_overflow;
    @(posedge clk) disable iff (!nrst)
    r_r.push |-> buf_in_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("read word pushed into full buffer");
endmodule : smi_ctrl

// File: src/smi_pkg.sv
// Shared constants and types of the synchronous memory interface controller
package smi_pkg;
  localparam int SMI_AW = 20;
  localparam int SMI_DW = 16;
  localparam int SMI_NSP = 4;
  localparam int SMI_SPW = 2;
  localparam int SMI_LATW = 2;
  localparam int SMI_TCW = 3;
  localparam int SMI_BUF_DEPTH = 2;
  localparam logic [SMI_LATW-1:0] SMI_LAT_ZERO = 2'h0;
  localparam logic [SMI_LATW-1:0] SMI_LAT_ONE = 2'h1;
  localparam logic [SMI_TCW-1:0] SMI_TC_ZERO = 3'h0;
  localparam logic [SMI_TCW-1:0] SMI_TC_ONE = 3'h1;
  localparam logic SMI_CLK_FIRST = 1'b0;
  localparam logic SMI_CLK_SECOND = 1'b1;

  typedef enum logic [2:0] {
    SMI_ST_IDLE = 3'h0,
    SMI_ST_CMD = 3'h1,
    SMI_ST_RLAT = 3'h2,
    SMI_ST_WLAT = 3'h3,
    SMI_ST_WDATA = 3'h4,
    SMI_ST_DESEL = 3'h5
  } smi_state_t;
endpackage : smi_pkg

// File: testbench/smi_mem_model.sv
// Behavioural synchronous memory on the far side of the link pins
`timescale 1ns/10ps
module smi_mem_model
  import smi_pkg::*;
(
  input wire logic if_clk, // Selected forwarded interface clock
  input wire logic nrst, // Reset, active low
  input wire logic [1:0] rd_lat, // Read latency of the active space
  input wire logic cs_n, // Chip select of the active space
  input wire logic all_cs_n, // High when no space is selected
  input wire logic oe_n, // Output enable, high outside read command through data phases
  input wire logic ads_n, // Address strobe or read enable
  input wire logic we_n, // Write enable
  input wire logic [smi_pkg::SMI_AW-1:0] addr, // Address pins
  input wire logic [smi_pkg::SMI_DW-1:0] dout, // Data from controller
  input wire logic doe, // Controller drives data
  output logic [smi_pkg::SMI_DW-1:0] din, // Data toward controller
  output logic [2:0] wr_gap, // Edges from write command to data
  output logic [7:0] desel_cnt // Deselect cycles seen
);
  logic [15:0] mem [16];
  logic [3:0] a_r;
  logic [2:0] k_r;
  logic busy_r, wr_r, drv_r;
  logic [15:0] last_r;
  // Released pins show the inverse, so a late sample cannot pass by luck
  assign din = drv_r ? last_r : ~last_r;
  always_ff @(posedge if_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_r <= 1'b0;
      wr_r <= 1'b0;
      drv_r <= 1'b0;
      a_r <= 4'h0;
      k_r <= 3'h0;
      last_r <= 16'h0;
      wr_gap <= 3'h0;
      desel_cnt <= 8'h00;
      for (int i = 0; i < 16; i++)
        mem[i] <= 16'h0;
    end
    else
    begin
      // A fifo read enable beside a dropped select is no deselect
      if (all_cs_n && oe_n && !ads_n)
        desel_cnt <= desel_cnt + 8'h01;
      if (!busy_r && !cs_n)
      begin
        busy_r <= we_n || !doe;
        wr_r <= !we_n;
        a_r <= addr[3:0];
        k_r <= 3'h0;
        last_r <= mem[addr[3:0]];
        drv_r <= we_n && rd_lat == 2'h0;
        wr_gap <= 3'h0;
        if (!we_n && doe)
          mem[addr[3:0]] <= dout;
      end
      else if (busy_r)
      begin
        k_r <= k_r + 3'h1;
        if (wr_r && doe)
        begin
          mem[a_r] <= dout;
          wr_gap <= k_r + 3'h1;
          busy_r <= 1'b0;
        end
        // data valid at edge latency plus one
        if (!wr_r)
        begin
          drv_r <= (k_r + 3'h1 == 3'(rd_lat)) || (k_r == 3'(rd_lat));
          if (k_r == 3'(rd_lat) + 3'h1)
            busy_r <= 1'b0;
        end
      end
    end
  end
endmodule : smi_mem_model

// File: testbench/sync_memory_iface_ctrl_tb.sv
// Self-checking bench of the synchronous memory port controller
`timescale 1ns/10ps
module sync_memory_iface_ctrl_tb;
  import smi_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic lclk1 = 1'b0;
  logic lclk2 = 1'b0;
  logic [3:0][1:0] rlat = '0;
  logic [3:0][1:0] wlat = '0;
  logic [3:0] cext = 4'h0;
  logic [3:0] fsel = 4'h0;
  logic [3:0] csel = 4'hA;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic rd_ready = 1'b0;
  logic [1:0] req_space = 2'h0;
  logic [19:0] req_addr = 20'h0;
  logic [15:0] req_wdata = 16'h0;
  logic req_ready, rd_valid, ck1, ck2, rs_n, os_n, ws_n, mdoe, cke_a, cke_b;
  logic [3:0] cs_n;
  logic [19:0] maddr;
  logic [15:0] rd_data, mdo, mdi;
  logic [2:0] wr_gap;
  logic [7:0] desel_cnt;
  int num_errors = 0;
  int check_count = 0;
  wire logic if_clk;
  // Memory clock trails the forwarded clock slightly, so the model takes the
  // pins launched on that same edge instead of racing them
  assign #1 if_clk = csel[req_space] ? ck2 : ck1;

  // System clock and two unrelated link clocks
  initial
    forever #50 clk = ~clk;
  initial
  begin
    #137;
    forever #400 lclk1 = ~lclk1;
  end
  initial
  begin
    #421;
    forever #400 lclk2 = ~lclk2;
  end

  smi_ctrl u_smi_ctrl (.clk(clk), .nrst(nrst), .link_clk_first_in(lclk1),
    .link_clk_second_in(lclk2), .read_latency_field(rlat), .write_latency_field(wlat),
    .chip_select_extension(cext), .strobe_function_select(fsel),
    .interface_clock_select(csel), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_space(req_space), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .ext_clock_out_first(ck1), .ext_clock_out_second(ck2), .space_chip_select_n(cs_n),
    .shared_read_strobe_pin_n(rs_n), .shared_output_strobe_pin_n(os_n),
    .shared_write_strobe_pin_n(ws_n), .mem_addr(maddr), .mem_data_out(mdo),
    .mem_data_oe(mdoe), .mem_data_in(mdi), .dram_clock_enable_out(cke_a));
  smi_ctrl #(.IS_FIRST_PORT(1'b0)) u_smi_ctrl_b (.clk(clk), .nrst(nrst),
    .link_clk_first_in(lclk1), .link_clk_second_in(lclk2), .read_latency_field(rlat),
    .write_latency_field(wlat), .chip_select_extension(cext), .strobe_function_select(fsel),
    .interface_clock_select(csel), .req_valid(1'b0), .req_ready(), .req_write(req_write),
    .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(),
    .rd_ready(rd_ready), .rd_data(), .ext_clock_out_first(), .ext_clock_out_second(),
    .space_chip_select_n(), .shared_read_strobe_pin_n(), .shared_output_strobe_pin_n(),
    .shared_write_strobe_pin_n(), .mem_addr(), .mem_data_out(), .mem_data_oe(),
    .mem_data_in(mdi), .dram_clock_enable_out(cke_b));
  smi_mem_model u_smi_mem_model (.if_clk(if_clk), .nrst(nrst), .rd_lat(rlat[req_space]),
    .cs_n(cs_n[req_space]), .all_cs_n(&cs_n), .oe_n(os_n), .ads_n(rs_n), .we_n(ws_n),
    .addr(maddr), .dout(mdo), .doe(mdoe), .din(mdi), .wr_gap(wr_gap), .desel_cnt(desel_cnt));

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  // A wait that runs out ends the run at once
  task automatic hang(input string what);
    $display("wrong value %s expected done seen timeout", what);
    num_errors++;
    results();
  endtask : hang

  task automatic wait_idle();
    int i;
    @(posedge clk);
    for (i = 0; i < 300; i++)
    begin
      @(negedge clk);
      if (req_ready === 1'b1)
        break;
    end
    if (i == 300)
      hang("idle");
  endtask : wait_idle

  // Request held until ready is seen high at a falling edge, then dropped at the next rising edge
  task automatic do_req(input logic wr, input logic [1:0] sp, input logic [19:0] a,
      input logic [15:0] d);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_space <= sp;
    req_addr <= a;
    req_wdata <= d;
    for (i = 0; i < 300; i++)
    begin
      @(negedge clk);
      if (req_ready === 1'b1)
        break;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    if (i == 300)
      hang("request");
  endtask : do_req

  task automatic take();
    @(posedge clk);
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
    @(negedge clk);
  endtask : take

  task automatic t_reset();
    int i;
    @(negedge clk);
    chk("selects", 20'hF, 20'(cs_n)); // idle high
    chk("strobes", 20'h7, 20'({rs_n, os_n, ws_n})); // idle high
    chk("ready", 20'h1, 20'({mdoe, rd_valid, req_ready})); // idle port
    for (i = 0; i < 40 && cke_a !== 1'b1; i++)
      @(negedge clk);
    chk("first cke", 20'h1, 20'(cke_a)); // first port
  endtask : t_reset

  task automatic t_write(input logic [1:0] sp, input logic [15:0] d);
    @(posedge clk);
    wlat[sp] <= sp;
    do_req(1'b1, sp, 20'(sp), d);
    wait_idle();
    chk("write gap", 20'(sp), 20'(wr_gap)); // latency
  endtask : t_write

  task automatic t_read(input logic [1:0] sp, input logic ext, input logic fn,
      input logic [15:0] exp);
    int i;
    int mism;
    int d0;
    @(posedge clk);
    rlat[sp] <= sp;
    cext[sp] <= ext;
    fsel[sp] <= fn;
    d0 = desel_cnt;
    mism = 0;
    do_req(1'b0, sp, 20'(sp), 16'h0);
    for (i = 0; i < 300 && rd_valid !== 1'b1; i++)
    begin
      @(negedge clk);
      if (cs_n[sp] !== os_n)
        mism++;
    end
    if (i == 300)
      hang("read");
    chk("read data", 20'(exp), 20'(rd_data)); // latency
    chk("select vs oe", 20'(ext), 20'(mism == 0)); // extension
    for (i = 0; i < 40 && desel_cnt == 8'(d0); i++)
      @(negedge clk);
    chk("deselects", 20'(!fn), 20'(desel_cnt - 8'(d0))); // strobe role
    take();
    wait_idle();
  endtask : t_read

  // Two unread words fill the buffer; a third read must wait
  task automatic t_buffer();
    int hi;
    do_req(1'b0, 2'h0, 20'h1, 16'h0);
    wait_idle();
    do_req(1'b0, 2'h0, 20'h2, 16'h0);
    hi = 0;
    repeat (200)
    begin
      @(negedge clk);
      if (req_ready === 1'b1)
        hi++;
    end
    chk("full refuses", 20'h0, 20'(hi)); // no word lost
    @(posedge clk);
    req_write <= 1'b1;
    @(negedge clk);
    chk("write room", 20'h1, 20'(req_ready)); // writes pass
    chk("word one", 20'hA5C1, 20'(rd_data)); // order kept
    take();
    chk("word two", 20'hA5C2, 20'(rd_data)); // order kept
    take();
    chk("empty", 20'h0, 20'(rd_valid)); // drained
  endtask : t_buffer

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    // Each latency once, spaces alternate between both clocks
    for (int w = 0; w < 4; w++)
      t_write(2'(w), 16'hA5C0 + 16'(w));
    for (int l = 0; l < 4; l++)
      t_read(2'(l), ~l[0], l[0] ^ l[1], 16'hA5C0 + 16'(l));
    t_buffer();
    chk("second cke", 20'h0, 20'(cke_b)); // second port
    results();
  end
endmodule : sync_memory_iface_ctrl_tb
